// File: inc/tvo_pkg.sv
package tvo_pkg;

	// ****************************************************************
	// Timecode word: hours, minutes, seconds and frames in binary.
	// ****************************************************************
	typedef struct packed
	{
		logic [4:0] hours;
		logic [5:0] minutes;
		logic [5:0] seconds;
		logic [4:0] frames;
	} tvo_tc_t;

	typedef enum logic {TVO_AV_LIVE, TVO_AV_BLACK} tvo_av_state_t;

	// ****************************************************************
	// Register byte addresses.
	// ****************************************************************
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_INIT   = 8'h04;
	localparam logic [7:0] ADDR_APPLY  = 8'h08;
	localparam logic [7:0] ADDR_OFFSET = 8'h0c;
	localparam logic [7:0] ADDR_STATUS = 8'h10;
	localparam logic [7:0] ADDR_TC     = 8'h14;

	// Control register bit positions and value after reset.
	localparam int CTRL_WALL   = 0;
	localparam int CTRL_DROP   = 1;
	localparam int CTRL_LTC    = 2;
	localparam int CTRL_VITC   = 3;
	localparam int CTRL_COMP0  = 4;
	localparam int CTRL_FILTER = 7;
	localparam int CTRL_AV     = 8;
	localparam int CTRL_W      = 9;
	localparam logic [8:0] CTRL_RESET = 9'h0f0;

	// Offset register layout: minutes, hours, sign (set = subtract).
	localparam int OFF_MIN_LSB = 0;
	localparam int OFF_HR_LSB  = 6;
	localparam int OFF_NEG     = 11;
	localparam int OFF_W       = 12;

	// Status register bit positions.
	localparam int STAT_NONSTD = 0;
	localparam int STAT_WALL   = 1;
	localparam int STAT_BLACK  = 2;
	localparam int STAT_DROP   = 3;

	// Clock arithmetic of the day and of the drop-frame scheme.
	localparam logic [11:0] MIN_PER_DAY  = 12'h5a0;
	localparam logic [11:0] MIN_PER_HOUR = 12'h03c;
	localparam logic [5:0]  LAST_SEC     = 6'h3b;
	localparam logic [5:0]  LAST_MIN     = 6'h3b;
	localparam logic [4:0]  LAST_HOUR    = 5'h17;
	localparam logic [5:0]  DROP_KEEP    = 6'h0a;
	localparam logic [4:0]  DROP_SKIP    = 5'h02;

	// AV cycle timing at the 50 MHz clock.
	localparam int CLK_HZ        = 50000000;
	localparam int AV_ON_MS      = 1000;
	localparam int AV_OFF_MS     = 4000;
	localparam int AV_ON_CYCLES  = AV_ON_MS * (CLK_HZ / 1000);
	localparam int AV_OFF_CYCLES = AV_OFF_MS * (CLK_HZ / 1000);
	localparam int AV_CNT_W      = 28;

	// Black levels of the luma-like and the difference-like components.
	localparam logic [9:0] Y_BLACK = 10'h040;
	localparam logic [9:0] C_BLACK = 10'h200;

endpackage

// File: inc/tvo_ctl_if.sv
`timescale 1ns/10ps
interface tvo_ctl_if;
	logic             wall_sel;
	logic             wall_present;
	logic             drop_active;
	logic             apply;
	logic             frame_tick;
	logic [4:0]       frame_max;
	logic [11:0]      offset;
	tvo_pkg::tvo_tc_t init_time;
	tvo_pkg::tvo_tc_t wall_tc;
	tvo_pkg::tvo_tc_t tc;
	logic [2:0]       comp_on;
	logic             gen_mode;
	logic             filt_en;
	logic             force_black;

	modport ctl
	(
		output wall_sel, wall_present, drop_active, apply, frame_tick, frame_max,
		output offset, init_time, wall_tc, comp_on, gen_mode, filt_en, force_black,
		input tc
	);
	modport tcm
	(
		input wall_sel, wall_present, drop_active, apply, frame_tick, frame_max,
		input offset, init_time, wall_tc,
		output tc
	);
	modport pix
	(
		input comp_on, gen_mode, filt_en, force_black
	);
endinterface

// File: core/tvo_timecode.sv
`timescale 1ns/10ps
module tvo_timecode
(
	input wire logic clk,
	input wire logic rst,
	tvo_ctl_if.tcm   ctl
);
	tvo_pkg::tvo_tc_t prog;
	tvo_pkg::tvo_tc_t next_prog;
	logic [11:0]      wall_mins;
	logic [11:0]      off_mins;
	logic [11:0]      sum_mins;
	logic [11:0]      day_mins;

	// Next frame count; minute starts off the tenth drop two frame numbers.
	always_comb
	begin
		next_prog = prog;
		if (prog.frames >= ctl.frame_max)
		begin
			next_prog.frames = 5'h00;
			if (prog.seconds == tvo_pkg::LAST_SEC)
			begin
				next_prog.seconds = 6'h00;
				if (prog.minutes == tvo_pkg::LAST_MIN)
				begin
					next_prog.minutes = 6'h00;
					next_prog.hours = (prog.hours == tvo_pkg::LAST_HOUR) ? 5'h00
						: prog.hours + 5'h01;
				end
				else
				begin
					next_prog.minutes = prog.minutes + 6'h01;
				end
				if (ctl.drop_active && (next_prog.minutes % tvo_pkg::DROP_KEEP != 6'h00))
				begin
					next_prog.frames = tvo_pkg::DROP_SKIP;
				end
			end
			else
			begin
				next_prog.seconds = prog.seconds + 6'h01;
			end
		end
		else
		begin
			next_prog.frames = prog.frames + 5'h01;
		end
	end

	// Program counter: apply without a module present loads the held initial time, else one step per frame.
	always_ff @(posedge clk)
	begin
		if (rst)
			prog <= '0;
		else if (ctl.apply && !ctl.wall_present)
			prog <= ctl.init_time;
		else if (ctl.frame_tick)
			prog <= next_prog;
	end

	// Signed offset on the received local time, wrapped into one day.
	assign wall_mins = 12'(ctl.wall_tc.hours) * tvo_pkg::MIN_PER_HOUR
		+ 12'(ctl.wall_tc.minutes);
	assign off_mins = 12'(ctl.offset[tvo_pkg::OFF_HR_LSB +: 5]) * tvo_pkg::MIN_PER_HOUR
		+ 12'(ctl.offset[tvo_pkg::OFF_MIN_LSB +: 6]);
	assign sum_mins = ctl.offset[tvo_pkg::OFF_NEG]
		? wall_mins + tvo_pkg::MIN_PER_DAY - off_mins
		: wall_mins + off_mins;
	assign day_mins = (sum_mins >= tvo_pkg::MIN_PER_DAY) ? sum_mins - tvo_pkg::MIN_PER_DAY
		: sum_mins;

	// Source select; the wall clock counts only while its module is present.
	always_ff @(posedge clk)
	begin
		if (rst)
			ctl.tc <= '0;
		else if (ctl.wall_sel && ctl.wall_present)
		begin
			ctl.tc.hours   <= 5'(day_mins / tvo_pkg::MIN_PER_HOUR);
			ctl.tc.minutes <= 6'(day_mins % tvo_pkg::MIN_PER_HOUR);
			ctl.tc.seconds <= ctl.wall_tc.seconds;
			ctl.tc.frames  <= ctl.wall_tc.frames;
		end
		else
			ctl.tc <= prog;
	end
endmodule

// File: core/tvo_pixel_path.sv
`timescale 1ns/10ps
module tvo_pixel_path
(
	input wire logic        clk,
	input wire logic        rst,
	tvo_ctl_if.pix          ctl,
	input wire logic        filt_capable,
	input wire logic        in_valid,
	input wire logic [29:0] in_data,
	output logic            out_valid,
	output logic [29:0]     out_data
);
	// Both paths deliver the centre tap, so toggling the filter keeps latency.
	genvar i;
	generate
		for (i = 0; i < 3; i++)
		begin : g_comp
			localparam logic [9:0] BLACK = (i == 0) ? tvo_pkg::Y_BLACK : tvo_pkg::C_BLACK;
			logic [9:0]  gated;
			logic [9:0]  d1;
			logic [9:0]  d2;
			logic [11:0] sum;

			// Component gate acts in generator mode; AV black acts always.
			assign gated = (ctl.force_black || (ctl.gen_mode && !ctl.comp_on[i])) ? BLACK
				: in_data[10*i +: 10];
			assign sum = {2'b00, gated} + {1'b0, d1, 1'b0} + {2'b00, d2} + 12'h002;

			// Tap line and output select.
			always_ff @(posedge clk)
			begin
				if (rst)
				begin
					d1 <= BLACK;
					d2 <= BLACK;
					out_data[10*i +: 10] <= BLACK;
				end
				else if (in_valid)
				begin
					d1 <= gated;
					d2 <= d1;
					out_data[10*i +: 10] <= (ctl.filt_en && filt_capable) ? sum[11:2]
						: d1;
				end
			end
		end
	endgenerate

	// Valid follows the data by one register.
	always_ff @(posedge clk)
	begin
		if (rst)
			out_valid <= 1'b0;
		else
			out_valid <= in_valid;
	end
endmodule

// File: core/tvo_video_output_ctrl.sv
// Function
// - Program source drives timecode from program counter.
// - Wall-clock source only with reference module present.
// - Wall-clock time taken as local time, then shifted by the offset.
// - Apply loads held initial time without module.
// - Signed offset up to 23:59 added to time.
// - Drop-frame counting only at non-integer rates.
// - Enable gates ancillary linear timecode insertion.
// - Independent enable gates vertical-interval timecode.
// - On/off gates first colour component.
// - On/off gates second colour component.
// - On/off gates third colour component.
// - Component gating only in generator mode.
// - Any non-default video setting flags non-standard.
// - Enabled edge filter low-passes level transitions on filter-capable outputs only.
// - Disabled filter switches levels instantly.
// - AV cycle: one second live, four black.
`timescale 1ns/10ps
module tvo_video_output_ctrl
#(
	parameter int unsigned AV_ON_CYCLES  = tvo_pkg::AV_ON_CYCLES,
	parameter int unsigned AV_OFF_CYCLES = tvo_pkg::AV_OFF_CYCLES
)
(
	input wire logic        clk,
	input wire logic        rst,
	input wire logic [7:0]  reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	output logic [31:0]     reg_rdata,
	input wire logic        wall_clock_present,
	input wire logic [21:0] wall_clock_time,
	input wire logic        frame_rate_integer,
	input wire logic [4:0]  frame_max,
	input wire logic        generator_mode,
	input wire logic        frame_start,
	input wire logic        filter_capable,
	input wire logic        vid_in_valid,
	input wire logic [29:0] vid_in_data,
	output logic            vid_out_valid,
	output logic [29:0]     vid_out_data,
	output logic [21:0]     timecode_out,
	output logic            anc_linear_timecode_enable,
	output logic            anc_vertical_interval_timecode_enable,
	output logic            name_nonstandard,
	output logic            audio_mute
);

	// ****************************************************************
	// Register state
	// ****************************************************************

	logic                          wall_clock_source;
	logic                          drop_frame_enable;
	logic                          ltc_enable;
	logic                          vitc_enable;
	logic [2:0]                    comp_on;
	logic                          edge_filter_enable;
	logic                          av_delay_cycle_mode;
	tvo_pkg::tvo_tc_t              init_time;
	logic [tvo_pkg::OFF_W-1:0]     tc_offset;
	logic                          apply_pulse;
	logic [tvo_pkg::CTRL_W-1:0]    ctrl_word;
	logic [31:0]                   next_rdata;
	logic                          drop_active;
	logic                          nonstandard;
	tvo_pkg::tvo_av_state_t        av_state;
	logic [tvo_pkg::AV_CNT_W-1:0]  av_count;
	logic                          av_black;

	tvo_ctl_if ctl_bus ();

	// Control register assembled for read back.
	assign ctrl_word = {av_delay_cycle_mode, edge_filter_enable, comp_on, vitc_enable,
		ltc_enable, drop_frame_enable, wall_clock_source};

	// Control bits; components and filter reset on, the rest off.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			wall_clock_source   <= tvo_pkg::CTRL_RESET[tvo_pkg::CTRL_WALL];
			drop_frame_enable   <= tvo_pkg::CTRL_RESET[tvo_pkg::CTRL_DROP];
			ltc_enable          <= tvo_pkg::CTRL_RESET[tvo_pkg::CTRL_LTC];
			vitc_enable         <= tvo_pkg::CTRL_RESET[tvo_pkg::CTRL_VITC];
			comp_on             <= tvo_pkg::CTRL_RESET[tvo_pkg::CTRL_COMP0 +: 3];
			edge_filter_enable  <= tvo_pkg::CTRL_RESET[tvo_pkg::CTRL_FILTER];
			av_delay_cycle_mode <= tvo_pkg::CTRL_RESET[tvo_pkg::CTRL_AV];
		end
		else if (reg_wr && reg_addr == tvo_pkg::ADDR_CTRL)
		begin
			wall_clock_source   <= reg_wdata[tvo_pkg::CTRL_WALL];
			drop_frame_enable   <= reg_wdata[tvo_pkg::CTRL_DROP];
			ltc_enable          <= reg_wdata[tvo_pkg::CTRL_LTC];
			vitc_enable         <= reg_wdata[tvo_pkg::CTRL_VITC];
			comp_on             <= reg_wdata[tvo_pkg::CTRL_COMP0 +: 3];
			edge_filter_enable  <= reg_wdata[tvo_pkg::CTRL_FILTER];
			av_delay_cycle_mode <= reg_wdata[tvo_pkg::CTRL_AV];
		end
	end

	// Initial time is only held here; it reaches the counter on apply.
	always_ff @(posedge clk)
	begin
		if (rst)
			init_time <= '0;
		else if (reg_wr && reg_addr == tvo_pkg::ADDR_INIT)
			init_time <= reg_wdata[21:0];
	end

	// Timecode offset, used only while the reference module is present.
	always_ff @(posedge clk)
	begin
		if (rst)
			tc_offset <= '0;
		else if (reg_wr && reg_addr == tvo_pkg::ADDR_OFFSET)
			tc_offset <= reg_wdata[tvo_pkg::OFF_W-1:0];
	end

	// Apply is a one-cycle command; the timecode block ignores it with a module present.
	always_ff @(posedge clk)
	begin
		if (rst)
			apply_pulse <= 1'b0;
		else
			apply_pulse <= reg_wr && reg_addr == tvo_pkg::ADDR_APPLY && reg_wdata[0];
	end

	// ****************************************************************
	// Register read port
	// ****************************************************************

	// Read mux; unmapped addresses and idle cycles return zero.
	always_comb
	begin
		next_rdata = 32'h0000_0000;
		if (reg_rd)
		begin
			unique case (reg_addr)
				tvo_pkg::ADDR_CTRL:   next_rdata = {23'h000000, ctrl_word};
				tvo_pkg::ADDR_INIT:   next_rdata = {10'h000, init_time};
				tvo_pkg::ADDR_OFFSET: next_rdata = {20'h00000, tc_offset};
				tvo_pkg::ADDR_STATUS:
				begin
					next_rdata[tvo_pkg::STAT_NONSTD] = nonstandard;
					next_rdata[tvo_pkg::STAT_WALL]   = wall_clock_present;
					next_rdata[tvo_pkg::STAT_BLACK]  = av_black;
					next_rdata[tvo_pkg::STAT_DROP]   = drop_active;
				end
				tvo_pkg::ADDR_TC:     next_rdata = {10'h000, ctl_bus.tc};
				default:              next_rdata = 32'h0000_0000;
			endcase
		end
	end

	// Read data stand only in the cycle after the strobe.
	always_ff @(posedge clk)
	begin
		if (rst)
			reg_rdata <= 32'h0000_0000;
		else
			reg_rdata <= next_rdata;
	end

	// ****************************************************************
	// Derived conditions
	// ****************************************************************

	// The stored drop choice is kept but ignored at integer frame rates.
	assign drop_active = drop_frame_enable && !frame_rate_integer;

	// Any video setting away from default marks the signal name.
	assign nonstandard = (comp_on != 3'h7) || !edge_filter_enable
		|| av_delay_cycle_mode;

	// ****************************************************************
	// AV timing cycle
	// ****************************************************************

	// Live for the on time, then black and muted for the off time, repeating.
	always_ff @(posedge clk)
	begin
		if (rst || !av_delay_cycle_mode)
		begin
			av_state <= tvo_pkg::TVO_AV_LIVE;
			av_count <= '0;
		end
		else
		begin
			unique case (av_state)
				tvo_pkg::TVO_AV_LIVE:
				begin
					if (av_count == tvo_pkg::AV_CNT_W'(AV_ON_CYCLES - 1))
					begin
						av_state <= tvo_pkg::TVO_AV_BLACK;
						av_count <= '0;
					end
					else
						av_count <= av_count + 1'b1;
				end
				tvo_pkg::TVO_AV_BLACK:
				begin
					if (av_count == tvo_pkg::AV_CNT_W'(AV_OFF_CYCLES - 1))
					begin
						av_state <= tvo_pkg::TVO_AV_LIVE;
						av_count <= '0;
					end
					else
						av_count <= av_count + 1'b1;
				end
			endcase
		end
	end

	assign av_black = av_state == tvo_pkg::TVO_AV_BLACK;

	// ****************************************************************
	// Submodule wiring
	// ****************************************************************

	// Control to the timecode and pixel blocks.
	assign ctl_bus.wall_sel     = wall_clock_source;
	assign ctl_bus.wall_present = wall_clock_present;
	assign ctl_bus.drop_active  = drop_active;
	assign ctl_bus.apply        = apply_pulse;
	assign ctl_bus.frame_tick   = frame_start;
	assign ctl_bus.frame_max    = frame_max;
	assign ctl_bus.offset       = tc_offset;
	assign ctl_bus.init_time    = init_time;
	assign ctl_bus.wall_tc      = wall_clock_time;
	assign ctl_bus.comp_on      = comp_on;
	assign ctl_bus.gen_mode     = generator_mode;
	assign ctl_bus.filt_en      = edge_filter_enable;
	assign ctl_bus.force_black  = av_black;

	tvo_timecode u_timecode
	(
		.clk (clk),
		.rst (rst),
		.ctl (ctl_bus)
	);

	tvo_pixel_path u_pixel
	(
		.clk          (clk),
		.rst          (rst),
		.ctl          (ctl_bus),
		.filt_capable (filter_capable),
		.in_valid     (vid_in_valid),
		.in_data      (vid_in_data),
		.out_valid    (vid_out_valid),
		.out_data     (vid_out_data)
	);

	// ****************************************************************
	// Outputs
	// ****************************************************************

	// Flags and timecode out of flip-flops, so they change only on a clock edge.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			timecode_out                          <= 22'h000000;
			anc_linear_timecode_enable            <= 1'b0;
			anc_vertical_interval_timecode_enable <= 1'b0;
			name_nonstandard                      <= 1'b0;
			audio_mute                            <= 1'b0;
		end
		else
		begin
			timecode_out                          <= ctl_bus.tc;
			anc_linear_timecode_enable            <= ltc_enable;
			anc_vertical_interval_timecode_enable <= vitc_enable;
			name_nonstandard                      <= nonstandard;
			audio_mute                            <= av_black;
		end
	end

endmodule

// File: bench/tvo_video_output_ctrl_assertions.sv
`timescale 1ns/10ps
module tvo_out_chk
(
	input wire logic        clk,
	input wire logic        rst,
	input wire logic [7:0]  reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic        wall_clock_present,
	input wire logic [4:0]  frame_max,
	input wire logic        frame_start,
	input wire logic        vid_in_valid,
	input wire logic        vid_out_valid,
	input wire logic [21:0] timecode_out,
	input wire logic        anc_linear_timecode_enable,
	input wire logic        anc_vertical_interval_timecode_enable,
	input wire logic        name_nonstandard
);
	// ****************************************************************
	// Shared shapes.
	// ****************************************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	// Nothing may move the program counter in this cycle.
	sequence s_quiet;
		!reg_wr && !wall_clock_present && !frame_start;
	endsequence

	// A control register write.
	sequence s_ctrl_wr;
		reg_wr && reg_addr == tvo_pkg::ADDR_CTRL;
	endsequence

	property p_copy(int b, logic o);
		logic v;
		(s_ctrl_wr, v = reg_wdata[b]) |-> ##2 o == v;
	endproperty

	property p_nonstd;
		logic [8:0] v;
		(s_ctrl_wr, v = reg_wdata[8:0]) |->
			##2 name_nonstandard == (v[6:4] != 3'h7 || !v[7] || v[8]);
	endproperty

	property p_readback;
		logic [21:0] v;
		(reg_wr && reg_addr == tvo_pkg::ADDR_INIT, v = reg_wdata[21:0])
			##1 (reg_rd && reg_addr == tvo_pkg::ADDR_INIT) |=> reg_rdata == {10'h0, v};
	endproperty

	// Four quiet cycles flush any earlier load through the output register.
	property p_step;
		logic [21:0] v;
		(s_quiet [*4] ##1 (frame_start && !reg_wr && !wall_clock_present
			&& timecode_out[4:0] < frame_max, v = timecode_out) ##1 !wall_clock_present)
			|-> ##2 timecode_out == v + 22'h1;
	endproperty

	// ****************************************************************
	// Assertions.
	// ****************************************************************
	a_ltc_copy: assert property (p_copy(tvo_pkg::CTRL_LTC, anc_linear_timecode_enable))
		else $error("linear timecode enable does not follow control");
	a_vitc_copy: assert property (p_copy(tvo_pkg::CTRL_VITC,
		anc_vertical_interval_timecode_enable))
		else $error("vertical timecode enable does not follow control");
	a_nonstd_flag: assert property (p_nonstd)
		else $error("non-standard flag wrong after control write");
	a_init_readback: assert property (p_readback)
		else $error("initial time not held as written");
	a_tc_hold: assert property (s_quiet [*4] |=> $stable(timecode_out))
		else $error("timecode moved without a cause");
	a_tc_step: assert property (p_step)
		else $error("program counter did not step by one frame");
	a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
		else $error("read data present without a read");
	a_valid_delay: assert property (1'b1 |=> vid_out_valid == $past(vid_in_valid))
		else $error("output valid does not follow input valid");
endmodule

bind tvo_video_output_ctrl tvo_out_chk tvo_out_chk_i
(
	.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
	.wall_clock_present, .frame_max, .frame_start, .vid_in_valid, .vid_out_valid,
	.timecode_out, .anc_linear_timecode_enable, .anc_vertical_interval_timecode_enable,
	.name_nonstandard
);

// File: bench/tvo_sink_model.sv
`timescale 1ns/10ps
module tvo_sink_model
(
	input wire logic        clk,
	input wire logic        valid,
	input wire logic [29:0] data,
	input wire logic        mute,
	output logic            got,
	output logic [29:0]     got_data,
	output logic [31:0]     mute_len,
	output logic [31:0]     live_len
);
	logic        last = 1'b0;
	logic [31:0] run = 32'h0;

	// Latch each word as a receiver would; the bench compares one cycle later.
	always_ff @(posedge clk)
	begin
		got <= valid;
		got_data <= data;
	end

	// Length of each muted and live stretch, published when the level turns.
	always_ff @(posedge clk)
	begin
		run <= (mute == last) ? run + 32'h1 : 32'h1;
		last <= mute;
		if (mute != last && last)
			mute_len <= run;
		if (mute != last && !last)
			live_len <= run;
	end
endmodule

// File: bench/test_tvo_video_output_ctrl.sv
`timescale 1ns/10ps
module test_tvo_video_output_ctrl;
	typedef struct packed {logic care; logic [29:0] d;} tvo_exp_t;
	localparam int unsigned ON  = 50;
	localparam int unsigned OFF = 200;
	localparam logic [29:0] BLK = {tvo_pkg::C_BLACK, tvo_pkg::C_BLACK, tvo_pkg::Y_BLACK};
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic        wall_clock_present = 1'b0;
	logic [21:0] wall_clock_time = 22'h0;
	logic        frame_rate_integer = 1'b0;
	logic [4:0]  frame_max = 5'h1d;
	logic        generator_mode = 1'b1;
	logic        frame_start = 1'b0;
	logic        filter_capable = 1'b0;
	logic        vid_in_valid = 1'b0;
	logic [29:0] vid_in_data = 30'h0;
	logic [31:0] reg_rdata, mute_len, live_len;
	logic [29:0] vid_out_data, got_data;
	logic [21:0] timecode_out;
	logic        vid_out_valid, ltc_en, vitc_en, name_nonstandard, audio_mute, got;
	logic        rd_q1 = 1'b0;
	logic [2:0]  off = 3'h0;
	logic        filt = 1'b0;
	logic        blk = 1'b0;
	logic [29:0] p1 = BLK;
	logic [29:0] p2 = BLK;
	logic [5:0]  cfg [5] = '{6'h34, 6'h29, 6'h00, 6'h3f, 6'h3e};
	logic [31:0] rd_q [$];
	tvo_exp_t    vq [$];
	tvo_exp_t    ve;
	int          errors = 0;
	int          total_checks = 0;
	int          cycles = 0;

	tvo_video_output_ctrl #(.AV_ON_CYCLES(ON), .AV_OFF_CYCLES(OFF)) tvo_video_output_ctrl_i
	(
		.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.wall_clock_present, .wall_clock_time, .frame_rate_integer, .frame_max,
		.generator_mode, .frame_start, .filter_capable, .vid_in_valid, .vid_in_data,
		.vid_out_valid, .vid_out_data, .timecode_out, .anc_linear_timecode_enable(ltc_en),
		.anc_vertical_interval_timecode_enable(vitc_en), .name_nonstandard, .audio_mute
	);
	tvo_sink_model tvo_sink_model_i
	(
		.clk, .valid(vid_out_valid), .data(vid_out_data), .mute(audio_mute),
		.got, .got_data, .mute_len, .live_len
	);

	// ****************************************************************
	// Clock, hang guard and result watcher.
	// ****************************************************************
	always #10 clk = ~clk;

	// The whole run needs well under a thousand cycles; far beyond that is a hang.
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			errors++;
			give_verdict();
		end
	end

	// Each answer takes the oldest note off its queue.
	always @(posedge clk)
	begin
		if (rd_q1)
			check("rdata", reg_rdata, rd_q.pop_front());
		rd_q1 <= reg_rd;
		if (got === 1'b1)
		begin
			ve = vq.pop_front();
			if (ve.care)
				check("video", {2'h0, got_data}, {2'h0, ve.d});
		end
	end

	// ****************************************************************
	// Tasks.
	// ****************************************************************
	task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Strobes are left high so back-to-back calls never assign twice in a step.
	task automatic wr(logic [7:0] a, logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		reg_rd <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rd(logic [7:0] a, logic [31:0] exp);
		rd_q.push_back(exp);
		reg_addr <= a;
		reg_rd <= 1'b1;
		reg_wr <= 1'b0;
		@(posedge clk);
	endtask

	task automatic idle(int n);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		frame_start <= 1'b0;
		vid_in_valid <= 1'b0;
		repeat (n) @(posedge clk);
	endtask

	task automatic step();
		frame_start <= 1'b1;
		@(posedge clk);
		idle(5);
	endtask

	task automatic tcchk(logic [21:0] exp);
		check("timecode", {10'h0, timecode_out}, {10'h0, exp});
	endtask

	task automatic wait_lvl(logic lvl);
		int n = 0;
		while (audio_mute !== lvl && n < 300)
		begin
			@(posedge clk);
			n++;
		end
		check("mute level", {31'h0, audio_mute}, {31'h0, lvl});
	endtask

	// The centre tap leaves; the filter weighs it against both neighbours.
	task automatic send(logic [29:0] x, logic care);
		logic [11:0] s;
		tvo_exp_t    e;
		logic [29:0] g;
		e.care = care;
		g = x;
		for (int i = 0; i < 3; i++)
		begin
			if (off[i] || blk)
				g[i*10+:10] = (i == 0) ? tvo_pkg::Y_BLACK : tvo_pkg::C_BLACK;
			s = {2'h0, g[i*10+:10]} + {1'h0, p1[i*10+:10], 1'h0} + {2'h0, p2[i*10+:10]} + 12'h2;
			e.d[i*10+:10] = filt ? s[11:2] : p1[i*10+:10];
		end
		vq.push_back(e);
		p2 = p1;
		p1 = g;
		vid_in_data <= x;
		vid_in_valid <= 1'b1;
		@(posedge clk);
	endtask

	function automatic logic [21:0] tc(int h, int m, int s, int f);
		return {5'(h), 6'(m), 6'(s), 5'(f)};
	endfunction

	// ****************************************************************
	// Main sequence.
	// ****************************************************************
	initial
	begin
		logic [21:0] t;
		logic [5:0]  c;
		void'($urandom(32'h2b87a229));
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		rd(tvo_pkg::ADDR_CTRL, 32'h0f0);
		wr(tvo_pkg::ADDR_STATUS, 32'hf);
		rd(tvo_pkg::ADDR_STATUS, 32'h0);
		rd(8'h40, 32'h0);
		for (int i = 0; i < 4; i++)
		begin
			wr(tvo_pkg::ADDR_CTRL, 32'h0f0 | (32'(i) << 2));
			idle(3);
			check("ltc", {31'h0, ltc_en}, {31'h0, i[0]});
			check("vitc", {31'h0, vitc_en}, {31'h0, i[1]});
		end
		$display("test registers and enables done");
		t = tc(1, $urandom_range(59), $urandom_range(59), 0);
		wr(tvo_pkg::ADDR_INIT, {10'h0, t});
		rd(tvo_pkg::ADDR_INIT, {10'h0, t});
		wr(tvo_pkg::ADDR_APPLY, 32'h1);
		idle(6);
		tcchk(t);
		repeat (3) step();
		tcchk(t + 22'h3);
		for (int i = 0; i < 3; i++)
		begin
			frame_rate_integer <= (i == 1);
			wr(tvo_pkg::ADDR_CTRL, 32'h0f2);
			wr(tvo_pkg::ADDR_INIT, {10'h0, tc(0, (i == 2) ? 9 : 0, 59, 29)});
			wr(tvo_pkg::ADDR_APPLY, 32'h1);
			idle(6);
			step();
			tcchk(tc(0, (i == 2) ? 10 : 1, 0, (i == 0) ? 2 : 0));
			rd(tvo_pkg::ADDR_STATUS, (i == 1) ? 32'h0 : 32'h8);
			idle(2);
		end
		$display("test program time done");
		wall_clock_present <= 1'b1;
		wall_clock_time <= tc(10, 20, 30, 5);
		wr(tvo_pkg::ADDR_OFFSET, 32'hade);
		wr(tvo_pkg::ADDR_CTRL, 32'h0f1);
		idle(5);
		tcchk(tc(22, 50, 30, 5));
		rd(tvo_pkg::ADDR_STATUS, 32'h2);
		wr(tvo_pkg::ADDR_OFFSET, 32'h36d);
		idle(5);
		tcchk(tc(0, 5, 30, 5));
		wr(tvo_pkg::ADDR_CTRL, 32'h0f0);
		wr(tvo_pkg::ADDR_APPLY, 32'h1);
		idle(6);
		tcchk(tc(0, 10, 0, 0));
		wall_clock_present <= 1'b0;
		$display("test wall clock done");
		for (int k = 0; k < 5; k++)
		begin
			c = cfg[k];
			generator_mode <= c[5];
			filter_capable <= c[0];
			wr(tvo_pkg::ADDR_CTRL, {24'h0, c[1], c[4:2], 4'h0});
			off = c[5] ? ~c[4:2] : 3'h0;
			filt = c[1] & c[0];
			idle(3);
			for (int j = 0; j < 6; j++)
				send(30'($urandom()), j >= 2);
			idle(4);
			check("nonstd", {31'h0, name_nonstandard}, {31'h0, c[4:2] != 3'h7 || !c[1]});
		end
		$display("test video gating and filter done");
		off = 3'h0;
		filt = 1'b0;
		wr(tvo_pkg::ADDR_CTRL, 32'h1f0);
		idle(1);
		wait_lvl(1'b1);
		blk = 1'b1;
		for (int j = 0; j < 4; j++)
			send(30'($urandom()), 1'b1);
		idle(1);
		blk = 1'b0;
		wait_lvl(1'b0);
		wait_lvl(1'b1);
		idle(2);
		check("black length", mute_len, OFF);
		check("live length", live_len, ON);
		wr(tvo_pkg::ADDR_CTRL, 32'h0f0);
		idle(4);
		check("mute", {31'h0, audio_mute}, 32'h0);
		$display("test av cycle done");
		give_verdict();
	end
endmodule
